/* File: logic/pscfg_consts.svh */
// Timing and width constants of the configuration-load handshake
`ifndef PSCFG_CONSTS_SVH
`define PSCFG_CONSTS_SVH
`define PSCFG_CLK_MHZ 100
`define PSCFG_T_REQ2LOW_NS 600
`define PSCFG_REQ2LOW_CYC ((`PSCFG_T_REQ2LOW_NS * `PSCFG_CLK_MHZ) / 1000)
`define PSCFG_T_STATUS_MIN_US 268
`define PSCFG_STATUS_MIN_CYC (`PSCFG_T_STATUS_MIN_US * `PSCFG_CLK_MHZ)
`define PSCFG_T_STATUS_MAX_US 1506
`define PSCFG_STATUS_MAX_CYC (`PSCFG_T_STATUS_MAX_US * `PSCFG_CLK_MHZ)
`define PSCFG_T_INIT_MIN_US 175
`define PSCFG_INIT_MIN_CYC (`PSCFG_T_INIT_MIN_US * `PSCFG_CLK_MHZ)
`define PSCFG_T_INIT_MAX_US 437
`define PSCFG_INIT_MAX_CYC (`PSCFG_T_INIT_MAX_US * `PSCFG_CLK_MHZ)
`define PSCFG_USER_INIT_CYC 8576
`define PSCFG_USER_INIT_WAIT_EDGES 4
`define PSCFG_EXTRA_FALL_EDGES 2
`define PSCFG_DATA_W 32
`define PSCFG_WORDS_DEF 16
`endif

/* File: logic/pscfg_loader.sv */
// Configuration-load handshake: request, status, data capture, initialization
// Overview of operation
// [RQ1] Request low drives load_complete low quickly
// [RQ2] Request low drives status_n low quickly
// [RQ3] Host holds request low at least 2 us
// [RQ4] status_n stays low 268 to 1506 us
// [RQ5] status_n rises within 1506 us
// [RQ6] Host waits before first config_clock edge
// [RQ7] Host keeps config_clock within frequency limits
// [RQ8] Oscillator init takes 175 to 437 us
// [RQ9] User clock init takes 8576 user clocks
// [RQ10] User mode: all high; request restarts
// [RQ11] status_n low through power-on reset delay
// [RQ12] load_complete low until loading done
// [RQ13] load_complete rises only after whole bitstream
// [RQ14] Two extra falling edges start initialization
// [RQ15] Host stalls config_clock only held low
// [RQ16] Host keeps config_clock at defined level
// [RQ17] init_complete low until initialization ends
// [RQ18] Host presents word every r clocks
// [RQ19] Serial data pin becomes user pin after
// [RQ20] Ratio one timing only without compression
// [RQ21] Data sampled on config_clock rise during load
// [RQ22] Host idles bus and restarts each time
`include "pscfg_consts.svh"
module pscfg_loader
  import pscfg_pkg::*;
#(
  parameter int WORDS = `PSCFG_WORDS_DEF, // Bitstream length in data words
  parameter int STATUS_CYC = `PSCFG_STATUS_MIN_CYC, // Reset phase length, cycles
  parameter int POR_CYC = `PSCFG_STATUS_MIN_CYC, // Power-on reset delay, cycles
  parameter int INIT_CYC = `PSCFG_INIT_MIN_CYC, // Oscillator init length, cycles
  parameter int USER_INIT_CYC = `PSCFG_USER_INIT_CYC // User clock init cycles
) (
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic config_request_n, // Reconfiguration request pin, active low
  input wire logic config_clock, // Host configuration clock pin
  input wire logic [`PSCFG_DATA_W-1:0] data_pins, // Parallel data pins
  input wire logic serial_data_pin_in, // Serial data pin, input side
  input wire pscfg_width_type load_width, // Load mode strap
  input wire logic use_user_init_clock, // Initialize from user_init_clock
  input wire logic user_init_clock, // Optional initialization clock pin
  input wire logic user_pin_out, // User logic drive for serial data pin
  input wire logic user_pin_oe, // User logic enable for serial data pin
  output logic serial_data_pin_out, // Serial data pin, output side
  output logic serial_data_pin_oe, // Serial data pin, output enable
  output logic [`PSCFG_DATA_W-1:0] cfg_word, // Last captured word
  output logic cfg_word_valid, // One-cycle pulse per captured word
  output pscfg_status_type status_pins // Status, completion and mode lines
);
  // Refuse counts that the sequencer cannot serve
  if (WORDS < 1 || STATUS_CYC < 1 || POR_CYC < 1 ||
      INIT_CYC < 1 || USER_INIT_CYC < 1) begin : g_bad_counts
    $error("pscfg_loader: counts must be at least one");
  end

  // Two-flop synchronisers for the request, both clock pins, serial data and data pins
  logic [3:0] s1_ff, s2_ff;
  logic [`PSCFG_DATA_W-1:0] d1_ff, d2_ff;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      // Idle pin levels: request high, both clocks low, data low.
      // Matching the edge detectors' reset avoids a false edge after reset.
      s1_ff <= 4'h8;
      s2_ff <= 4'h8;
      d1_ff <= '0;
      d2_ff <= '0;
    end else begin
      s1_ff <= {config_request_n, config_clock, serial_data_pin_in, user_init_clock};
      s2_ff <= s1_ff;
      d1_ff <= data_pins;
      d2_ff <= d1_ff;
    end
  end
  logic req_n, cclk, sdat, uclk;
  assign {req_n, cclk, sdat, uclk} = s2_ff;

  // Edge detection on synchronised copies
  logic cclk_d_ff, uclk_d_ff;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cclk_d_ff <= 1'b0;
      uclk_d_ff <= 1'b0;
    end else begin
      cclk_d_ff <= cclk;
      uclk_d_ff <= uclk;
    end
  end
  logic cclk_rise, cclk_fall, uclk_rise;
  assign cclk_rise = cclk & ~cclk_d_ff;
  assign cclk_fall = ~cclk & cclk_d_ff;
  assign uclk_rise = uclk & ~uclk_d_ff;

  // Bits per word for the selected mode
  function automatic logic [5:0] bits_per_word(input pscfg_width_type w);
    case (w)
      PSCFG_W8: bits_per_word = 6'h08;
      PSCFG_W16: bits_per_word = 6'h10;
      PSCFG_W32: bits_per_word = 6'h20;
      default: bits_per_word = 6'h01;
    endcase
  endfunction

  // Main sequencer
  pscfg_state_type state_ff, nxt_state;
  logic [31:0] cnt_ff;
  logic [31:0] words_ff;
  logic [5:0] bits_ff;
  logic [1:0] fall_ff;
  logic fall_armed_ff; // Clock seen low since completion
  logic req_low;
  logic load_go;
  assign req_low = ~req_n;
  assign load_go = (state_ff == ST_LOAD) && cclk_rise; // [RQ21]

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_POR: if (cnt_ff >= 32'(POR_CYC - 1) && req_n) nxt_state = ST_LOAD; // [RQ11]
      ST_RESET: if (cnt_ff >= 32'(STATUS_CYC - 1) && req_n) nxt_state = ST_LOAD; // [RQ4] [RQ5]
      ST_LOAD: if (load_go && words_ff == 32'(WORDS - 1) &&
                   (load_width != PSCFG_SERIAL || bits_ff == 6'h1F))
        nxt_state = ST_DONE; // [RQ13]
      ST_DONE: if (cclk_fall && fall_armed_ff && fall_ff == 2'(`PSCFG_EXTRA_FALL_EDGES - 1))
        nxt_state = ST_INIT; // [RQ14]
      // User clock rises are counted one by one, so all of them must be seen
      ST_INIT: if (cnt_ff >= (use_user_init_clock ? 32'(USER_INIT_CYC) : 32'(INIT_CYC - 1)))
        nxt_state = ST_USER; // [RQ8] [RQ9]
      ST_USER: nxt_state = ST_USER;
      default: nxt_state = ST_POR;
    endcase
    if (req_low && state_ff != ST_POR) nxt_state = ST_RESET; // [RQ10]
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) state_ff <= ST_POR;
    else state_ff <= nxt_state;
  end

  // Phase counter: counts cycles, or user clock edges once those are enabled
  logic [2:0] uwait_ff;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= '0;
      uwait_ff <= '0;
    end else if (nxt_state != state_ff) begin
      cnt_ff <= '0;
      uwait_ff <= '0;
    end else if (state_ff == ST_INIT && use_user_init_clock) begin
      // User clock counted only after four rises of config_clock or user_init_clock
      if (uwait_ff < 3'(`PSCFG_USER_INIT_WAIT_EDGES)) begin
        if (cclk_rise || uclk_rise) uwait_ff <= uwait_ff + 3'h1; // [RQ9]
      end else if (uclk_rise) cnt_ff <= cnt_ff + 32'h1; // [RQ9]
    end else if (state_ff != ST_LOAD && state_ff != ST_DONE && state_ff != ST_USER) begin
      if (state_ff != ST_RESET || req_n) cnt_ff <= cnt_ff + 32'h1; // [RQ4]
    end
  end

  // Data capture and word counting
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      words_ff <= '0;
      bits_ff <= '0;
      cfg_word <= '0;
      cfg_word_valid <= 1'b0;
    end else begin
      cfg_word_valid <= 1'b0;
      if (state_ff != ST_LOAD) begin
        words_ff <= '0; // Each reload restarts from the first word
        bits_ff <= '0;
      end else if (load_go) begin
        if (load_width == PSCFG_SERIAL) begin
          cfg_word <= {sdat, cfg_word[`PSCFG_DATA_W-1:1]}; // [RQ21]
          bits_ff <= bits_ff + 6'h1;
          if (bits_ff == 6'h1F) begin
            bits_ff <= '0;
            words_ff <= words_ff + 32'h1;
            cfg_word_valid <= 1'b1;
          end
        end else begin
          cfg_word <= d2_ff & ({`PSCFG_DATA_W{1'b1}} >> (6'h20 - bits_per_word(load_width)));
          // One word per rise: no decompression or decryption stage here
          words_ff <= words_ff + 32'h1; // [RQ20]
          cfg_word_valid <= 1'b1; // [RQ21]
        end
      end
    end
  end

  // Extra falling edges after completion. The fall of the clock that carried
  // the last word is not one of them, so counting arms only once the clock
  // has been seen low in the completion phase.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fall_ff <= '0;
      fall_armed_ff <= 1'b0;
    end else if (state_ff != ST_DONE) begin
      fall_ff <= '0;
      fall_armed_ff <= 1'b0;
    end else begin
      if (!cclk) fall_armed_ff <= 1'b1;
      if (cclk_fall && fall_armed_ff) fall_ff <= fall_ff + 2'h1; // [RQ14]
    end
  end

  // Status pins are registered from the sequencer state
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) status_pins <= '{status_n: 1'b0, load_complete: 1'b0,
                                  init_complete: 1'b0, user_mode: 1'b0};
    else begin
      status_pins.status_n <= !(nxt_state == ST_POR || nxt_state == ST_RESET); // [RQ2] [RQ11]
      status_pins.load_complete <= (nxt_state == ST_DONE || nxt_state == ST_INIT ||
                                    nxt_state == ST_USER); // [RQ1] [RQ12]
      status_pins.init_complete <= (nxt_state == ST_USER); // [RQ17]
      status_pins.user_mode <= (nxt_state == ST_USER); // [RQ10]
    end
  end

  // Serial data pin handed to user logic only in user mode
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      serial_data_pin_out <= 1'b0;
      serial_data_pin_oe <= 1'b0;
    end else begin
      serial_data_pin_out <= user_pin_out;
      serial_data_pin_oe <= (nxt_state == ST_USER) && user_pin_oe; // [RQ19]
    end
  end

  // Checks
  property p_req_status;
    @(posedge sys_clk) disable iff (!resetn) $fell(req_n) |-> ##[1:2] !status_pins.status_n;
  endproperty
  a_req_status: assert property (p_req_status) else $error("status_n not low after request"); // [RQ2]
  property p_req_done;
    @(posedge sys_clk) disable iff (!resetn) $fell(req_n) |-> ##[1:2] !status_pins.load_complete;
  endproperty
  a_req_done: assert property (p_req_done) else $error("load_complete not low"); // [RQ1]
  property p_status_min;
    @(posedge sys_clk) disable iff (!resetn)
      $fell(status_pins.status_n) |-> !status_pins.status_n [*8];
  endproperty
  a_status_min: assert property (p_status_min) else $error("status_n low too short"); // [RQ4]
  property p_done_only_load;
    @(posedge sys_clk) disable iff (!resetn)
      $rose(status_pins.load_complete) |-> $past(state_ff) == ST_LOAD;
  endproperty
  a_done_only_load: assert property (p_done_only_load) else $error("early completion"); // [RQ13]
  property p_done_status;
    @(posedge sys_clk) disable iff (!resetn)
      status_pins.load_complete |-> status_pins.status_n;
  endproperty
  a_done_status: assert property (p_done_status) else $error("complete while in reset"); // [RQ12]
  property p_init_after;
    @(posedge sys_clk) disable iff (!resetn)
      status_pins.init_complete |-> status_pins.load_complete && status_pins.status_n;
  endproperty
  a_init_after: assert property (p_init_after) else $error("init_complete early"); // [RQ17]
  property p_user_pin;
    @(posedge sys_clk) disable iff (!resetn) serial_data_pin_oe |-> status_pins.user_mode;
  endproperty
  a_user_pin: assert property (p_user_pin) else $error("pin driven outside user mode"); // [RQ19]
  property p_capture;
    @(posedge sys_clk) disable iff (!resetn)
      cfg_word_valid |-> $past(state_ff) == ST_LOAD && $past(cclk_rise);
  endproperty
  a_capture: assert property (p_capture) else $error("capture outside load"); // [RQ21]
  property p_init_len;
    @(posedge sys_clk) disable iff (!resetn)
      $rose(status_pins.load_complete) |-> !status_pins.user_mode [*3];
  endproperty
  a_init_len: assert property (p_init_len) else $error("user mode too soon"); // [RQ8]
  c_reconfig: cover property (@(posedge sys_clk) $fell(req_n) && status_pins.user_mode);
  c_complete: cover property (@(posedge sys_clk) $rose(status_pins.load_complete));
  c_user: cover property (@(posedge sys_clk) $rose(status_pins.user_mode));
endmodule

/* File: logic/pscfg_pkg.sv */
// Types shared by the configuration-load handshake
package pscfg_pkg;
  typedef enum logic [1:0] {
    PSCFG_W8,
    PSCFG_W16,
    PSCFG_W32,
    PSCFG_SERIAL
  } pscfg_width_type;

  typedef enum {
    ST_POR,
    ST_RESET,
    ST_LOAD,
    ST_DONE,
    ST_INIT,
    ST_USER
  } pscfg_state_type;

  // Pins driven by the device
  typedef struct packed {
    logic status_n;
    logic load_complete;
    logic init_complete;
    logic user_mode;
  } pscfg_status_type;
endpackage

/* File: verif/pscfg_host.sv */
// Host model: request pulse, configuration clock, data and init clock
module pscfg_host (
  input wire logic sys_clk, // Bench clock
  output logic config_request_n, // Request pin, active low
  output logic config_clock, // Configuration clock, idles low
  output logic [31:0] data_pins, // Parallel data pins
  output logic serial_data_pin_in, // Serial data pin
  output logic user_init_clock // Initialization clock, idles low
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle levels from time zero
  initial begin
    config_request_n = 1'h1;
    config_clock = 1'h0;
    data_pins = 32'h0;
    serial_data_pin_in = 1'h0;
    user_init_clock = 1'h0;
  end
  // Request level; the bench times the low pulse
  task automatic set_req(input logic v);
    @(posedge sys_clk);
    config_request_n <= v;
  endtask
  // One 80 ns clock period with data ahead of the rise
  task automatic clk_pulse(input logic [31:0] d, input logic s);
    @(posedge sys_clk);
    data_pins <= d;
    serial_data_pin_in <= s;
    repeat (3) @(posedge sys_clk);
    config_clock <= 1'h1;
    repeat (4) @(posedge sys_clk);
    config_clock <= 1'h0;
    // Hold time over: show the inverse so stale data never matches
    data_pins <= ~d;
    serial_data_pin_in <= ~s;
  endtask
  // Whole word: 32 bits LSB first when serial, else one rise
  task automatic send_word(input logic [31:0] w, input logic serial);
    if (serial) begin
      for (int i = 0; i < 32; i++) clk_pulse(32'h0, w[i]);
    end else begin
      clk_pulse(w, 1'h0);
    end
  endtask
  // One 70 ns period of the initialization clock
  task automatic uclk_pulse;
    @(posedge sys_clk);
    user_init_clock <= 1'h1;
    repeat (3) @(posedge sys_clk);
    user_init_clock <= 1'h0;
    repeat (3) @(posedge sys_clk);
  endtask
endmodule

/* File: verif/pscfg_loader_tb.sv */
// Self-checking bench of the configuration-load handshake
module pscfg_loader_tb;
  import pscfg_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WORDS = 4; // Short bitstream
  localparam int STATUS_CYC = 20; // Short reset phase
  localparam int POR_CYC = 20; // Short power-on delay
  localparam int INIT_CYC = 20; // Short oscillator init
  localparam int USER_CYC = 10; // Short user clock init
  logic sys_clk, resetn, req_n, cclk, sdi, use_uclk, uclk, upin, upin_oe;
  logic [31:0] data, cfg_word;
  pscfg_width_type load_width;
  logic sdo, sdo_oe, word_valid;
  pscfg_status_type st;
  int fails = 0;
  int total_checks = 0;
  int nvalid = 0;
  int cycles = 0;
  pscfg_loader #(.WORDS(WORDS), .STATUS_CYC(STATUS_CYC), .POR_CYC(POR_CYC),
    .INIT_CYC(INIT_CYC), .USER_INIT_CYC(USER_CYC)) dut (.sys_clk(sys_clk),
    .resetn(resetn), .config_request_n(req_n), .config_clock(cclk), .data_pins(data),
    .serial_data_pin_in(sdi), .load_width(load_width), .use_user_init_clock(use_uclk),
    .user_init_clock(uclk), .user_pin_out(upin), .user_pin_oe(upin_oe),
    .serial_data_pin_out(sdo), .serial_data_pin_oe(sdo_oe), .cfg_word(cfg_word),
    .cfg_word_valid(word_valid), .status_pins(st));
  pscfg_host host (.sys_clk(sys_clk), .config_request_n(req_n), .config_clock(cclk),
    .data_pins(data), .serial_data_pin_in(sdi), .user_init_clock(uclk));
  // 100 MHz clock
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Count word pulses; a pulse stands one cycle so it is seen at exactly one edge
  always @(posedge sys_clk) if (word_valid === 1'h1) nvalid++;
  // Hang guard, well above the expected run
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      end_sim();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Power-on: status_n low through the delay, then released
  task automatic t_powerup;
    int n = 0;
    repeat (3) @(posedge sys_clk);
    check(st.status_n, 1'h0);
    check(st.load_complete, 1'h0);
    while (st.status_n !== 1'h1 && n < POR_CYC + 40) begin
      @(posedge sys_clk);
      n++;
    end
    check(32'(n >= POR_CYC - 4 && n <= POR_CYC + 10), 32'h1);
    $display("powerup done");
  endtask
  // 2 us request pulse; status_n and load_complete fall within 600 ns, status_n rises after the phase
  task automatic t_request;
    int n = 0;
    host.set_req(1'h0);
    repeat (60) @(posedge sys_clk);
    check(st.status_n, 1'h0);
    check(st.load_complete, 1'h0);
    repeat (140) @(posedge sys_clk);
    host.set_req(1'h1);
    while (st.status_n !== 1'h1 && n < STATUS_CYC + 40) begin
      @(posedge sys_clk);
      n++;
    end
    check(32'(n >= STATUS_CYC - 2 && n <= STATUS_CYC + 10), 32'h1);
    repeat (200) @(posedge sys_clk);
    $display("request done");
  endtask
  // Load WORDS words in one mode, then the two extra falling edges
  task automatic t_load(input pscfg_width_type m, input logic u);
    logic [31:0] w, mask;
    int n0;
    mask = (m == PSCFG_W8) ? 32'hFF : (m == PSCFG_W16) ? 32'hFFFF : 32'hFFFFFFFF;
    n0 = nvalid;
    load_width <= m;
    use_uclk <= u;
    check(sdo_oe, 1'h0);
    for (int i = 0; i < WORDS; i++) begin
      w = 32'h5A3C96E1 ^ (32'h11111111 * i);
      check(st.load_complete, 1'h0);
      host.send_word(w, m == PSCFG_SERIAL);
      repeat (3) @(posedge sys_clk);
      check(cfg_word & mask, w & mask);
    end
    check(32'(nvalid - n0), 32'(WORDS));
    check(st.load_complete, 1'h1);
    check(st.init_complete, 1'h0);
    host.clk_pulse(32'h0, 1'h0);
    host.clk_pulse(32'h0, 1'h0);
    $display("load done");
  endtask
  // Initialization from the oscillator or the user clock
  task automatic t_init(input logic u);
    int n = 0;
    while (st.user_mode !== 1'h1 && n < 200) begin
      if (u) host.uclk_pulse();
      else @(posedge sys_clk);
      n++;
    end
    if (u) check(32'(n >= USER_CYC && n <= USER_CYC + 6), 32'h1);
    else check(32'(n >= INIT_CYC - 2 && n <= INIT_CYC + 12), 32'h1);
    check(st, 4'hF);
    $display("init done");
  endtask
  // Serial data pin follows user logic once in user mode
  task automatic t_user_pin;
    upin_oe <= 1'h1;
    upin <= 1'h1;
    repeat (5) @(posedge sys_clk);
    check({sdo_oe, sdo}, 2'h3);
    upin <= 1'h0;
    repeat (5) @(posedge sys_clk);
    check({sdo_oe, sdo}, 2'h2);
    $display("user pin done");
  endtask
  task automatic end_sim;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence: every parallel width, then serial with the user clock
  initial begin
    resetn = 1'h0;
    load_width = PSCFG_W32;
    use_uclk = 1'h0;
    upin = 1'h0;
    upin_oe = 1'h0;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'h1;
    t_powerup();
    for (int k = 0; k < 3; k++) begin
      t_request();
      t_load(pscfg_width_type'(k), 1'h0);
      t_init(1'h0);
    end
    t_request();
    t_load(PSCFG_SERIAL, 1'h1);
    t_init(1'h1);
    t_user_pin();
    end_sim();
  end
endmodule
